// file: logic/fpc_pkg.sv
// Package of constants and carrier types for the flash program control block
package fpc_pkg;

   // ----------------------------------------
   // Register offsets (special function space)
   // ----------------------------------------
   localparam logic [7:0] FPC_FLASH_CONTROL_ADDR = 8'hd1;
   localparam logic [7:0] FPC_FLASH_STATUS_ADDR  = 8'hd3;
   localparam logic [7:0] FPC_AUX_CONTROL_ADDR   = 8'ha2;

   // ----------------------------------------
   // Field positions and values
   // ----------------------------------------
   localparam int         FPC_KEY_MSB         = 7;
   localparam int         FPC_KEY_LSB         = 4;
   localparam int         FPC_MAP_BIT         = 3;
   localparam int         FPC_MODE_MSB        = 2;
   localparam int         FPC_MODE_LSB        = 1;
   localparam int         FPC_BUSY_BIT        = 0;
   localparam int         FPC_SEQUENCE_ERROR_FLAG_BIT      = 1;
   localparam int         FPC_LOADED_BIT      = 0;
   localparam int         FPC_BOOTMAP_BIT     = 5;
   localparam int         FPC_CFG_RATE_BIT    = 7;
   localparam int         FPC_CFG_JUMP_BIT    = 6;
   localparam logic [3:0] FPC_KEY_FIRST       = 4'h5;
   localparam logic [3:0] FPC_KEY_SECOND      = 4'ha;
   localparam logic [7:0] FPC_CONTROL_RESET   = 8'h00;
   localparam logic [7:0] FPC_STATUS_RESET    = 8'h00;
   localparam logic [7:0] FPC_CFG_SW_MASK     = 8'hf0;
   localparam logic [7:0] FPC_CFG_LOCK_MASK   = 8'h07;

   // ----------------------------------------
   // Addresses and sizes
   // ----------------------------------------
   localparam logic [15:0] FPC_START_USER     = 16'h0000;
   localparam logic [15:0] FPC_START_BOOT     = 16'hf800;
   localparam logic [15:0] FPC_EXTRA_CONFIG_ROW_BASE      = 16'hff80;
   localparam logic [15:0] FPC_CFG_ADDR       = 16'h0000;
   localparam int          FPC_PAGE_BYTES     = 128;
   localparam int          FPC_RATE_DOUBLE    = 6;
   localparam int          FPC_RATE_SINGLE    = 12;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int          FPC_CLK_NS         = 100;
   localparam int          FPC_PROG_TIME_NS   = 10000;
   localparam int          FPC_PROG_CYCLES    = (FPC_PROG_TIME_NS + FPC_CLK_NS - 1) / FPC_CLK_NS;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {
      FPC_SPACE_USER  = 2'b00,
      FPC_SPACE_EXTRA_CONFIG_ROW  = 2'b01,
      FPC_SPACE_CFG   = 2'b10,
      FPC_SPACE_CLRST = 2'b11
   } fpc_space_type;

   typedef enum logic [1:0] {
      FPC_EXEC_USER = 2'b00,
      FPC_EXEC_BOOT = 2'b01,
      FPC_EXEC_EXT  = 2'b10
   } fpc_exec_type;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [7:0]  wdata;
   } fpc_sfr_type;

   typedef struct packed {
      logic        wr;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } fpc_xdata_type;

   typedef struct packed {
      logic        start;
      logic [1:0]  space;
      logic [8:0]  page;
   } fpc_launch_type;

endpackage : fpc_pkg

// file: logic/fpc_column_latch.sv
// Page-wide write-only column latch buffer
`timescale 1ns/1ps
module fpc_column_latch
   import fpc_pkg::*;
#(
   parameter int DEPTH = FPC_PAGE_BYTES,
   parameter int AW    = $clog2(DEPTH)
) (
   input  wire logic          i_mclk,
   input  wire logic          i_rst_n,
   input  wire logic          i_ce,
   input  wire logic          i_wr,
   input  wire logic [AW-1:0] i_idx,
   input  wire logic [7:0]    i_wdata,
   input  wire logic          i_clear,
   input  wire logic [AW-1:0] i_rd_idx,
   output logic [7:0]         o_rd_data,
   output logic               o_rd_valid
);

   // ----------------------------------------
   // Storage; only the programming engine reads it
   // ----------------------------------------
   logic [7:0]       mem       [DEPTH];
   logic [DEPTH-1:0] valid;
   logic [DEPTH-1:0] next_valid;
   logic [7:0]       rd_data;
   logic             rd_valid;

   always_comb begin
      next_valid = valid;
      if (i_clear) begin
         next_valid = '0;
      end else if (i_wr) begin
         next_valid[i_idx] = 1'b1;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         valid <= '0;
      end else if (i_ce) begin
         valid <= next_valid;
      end
   end

   // Array kept out of reset so it maps to plain memory
   always_ff @(posedge i_mclk) begin
      if (i_ce && i_wr) begin
         mem[i_idx] <= i_wdata; // R6
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         rd_data  <= 8'h00;
         rd_valid <= 1'b0;
      end else if (i_ce) begin
         rd_data  <= mem[i_rd_idx];
         rd_valid <= valid[i_rd_idx];
      end
   end

   assign o_rd_data  = rd_data;
   assign o_rd_valid = rd_valid;

endmodule : fpc_column_latch

// file: logic/fpc_prog_timer.sv
// Programming operation timer that holds the busy state
`timescale 1ns/1ps
module fpc_prog_timer
   import fpc_pkg::*;
#(
   parameter int CYCLES = FPC_PROG_CYCLES,
   parameter int CW     = $clog2(CYCLES + 1)
) (
   input  wire logic i_mclk,
   input  wire logic i_rst_n,
   input  wire logic i_ce,
   input  wire logic i_start,
   output logic      o_busy,
   output logic      o_done
);

   // ----------------------------------------
   // Down counter
   // ----------------------------------------
   logic [CW-1:0] count;
   logic [CW-1:0] next_count;
   logic          done;
   logic          next_done;

   always_comb begin
      next_count = count;
      next_done  = 1'b0;
      if (count != '0) begin
         next_count = count - 1'b1;
         next_done  = (count == CW'(1)); // R15
      end else if (i_start) begin
         next_count = CW'(CYCLES); // R14
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         count <= '0;
         done  <= 1'b0;
      end else if (i_ce) begin
         count <= next_count;
         done  <= next_done;
      end
   end

   assign o_busy = (count != '0);
   assign o_done = done;

endmodule : fpc_prog_timer

// file: logic/fpc_flash_program_control.sv
// Flash program control: control, status, column latches, access guard, start-up decode
//
// Summary of operation
// R1: Programmed rate bit gives six-clock mode
// R2: Unprogrammed rate bit gives standard mode
// R3: Unprogrammed jump bit: boot map off, 0000h
// R4: Programmed jump bit: boot map on, F800h
// R5: Lock bits never written by software
// R6: One 128-byte page of column latches
// R7: Column latches cannot be read back
// R8: User array programs only from boot
// R9: Boot array never written by software
// R10: External fetch: lock-gated reads, no loads
// R11: Three registers map flash spaces
// R12: Software writes key 5 then A
// R13: Map bit steers data writes to latches
// R14: Busy flag set while programming
// R15: Busy flag clears when programming ends
// R16: Busy flag ignores software writes
// R17: Control register resets to zero
// R18: Mode field selects code read space
// R19: Low seven bits byte, upper page
// R20: Sequence error flag on bad key pair
// R21: Loaded flag on latch write, launch clears
// R22: No launch while busy or wrong keys
// R23: Software waits for busy clear
`timescale 1ns/1ps
module fpc_flash_program_control
   import fpc_pkg::*;
#(
   parameter int           PROG_CYCLES = FPC_PROG_CYCLES,
   parameter logic [2:0]   LOCK_READ_OK = 3'b111
) (
   input  wire logic           i_mclk,
   input  wire logic           i_rst_n,
   input  wire logic           i_ce,
   input  wire fpc_sfr_type    i_sfr,
   output logic [7:0]          o_sfr_rdata,
   input  wire fpc_xdata_type  i_xdata,
   output logic                o_xdata_to_ram,
   input  wire fpc_exec_type   i_exec_region,
   input  wire logic [15:0]    i_code_addr,
   output fpc_space_type       o_code_space,
   output logic                o_code_read_ok,
   input  wire logic [7:0]     i_security_config_byte,
   output logic                o_double_rate_mode,
   output logic [3:0]          o_clocks_per_cycle,
   output logic [15:0]         o_start_address,
   output logic                o_boot_space_map,
   output logic [2:0]          o_general_lock_bits,
   output fpc_launch_type      o_launch,
   output logic                o_program_busy_flag,
   output logic [7:0]          o_latch_rd_data,
   output logic                o_latch_rd_valid,
   input  wire logic [6:0]     i_latch_rd_idx
);

   // ----------------------------------------
   // Security byte sync and start-up decode
   // ----------------------------------------
   logic [7:0]  cfg_meta;
   logic [7:0]  cfg_sync;
   logic        double_rate_mode;
   logic        next_double_rate_mode;
   logic        boot_space_map;
   logic        next_boot_space_map;
   logic [15:0] start_address;
   logic [15:0] next_start_address;
   logic [2:0]  lock_bits;
   logic [2:0]  next_lock_bits;
   logic        strap_done;
   logic        next_strap_done;
   logic        strap_armed;
   logic        next_strap_armed;
   logic        strap_wait;
   logic        next_strap_wait;

   // Byte lives in flash, so it is a pin-like level here
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         cfg_meta <= 8'hff;
         cfg_sync <= 8'hff;
      end else if (i_ce) begin
         cfg_meta <= i_security_config_byte;
         cfg_sync <= cfg_meta;
      end
   end

   // Straps caught once, on the third edge after release, when the sync chain is full
   always_comb begin
      next_double_rate_mode = double_rate_mode;
      next_boot_space_map   = boot_space_map;
      next_start_address    = start_address;
      next_lock_bits        = lock_bits;
      next_strap_wait       = 1'b1;
      next_strap_armed      = strap_wait;
      next_strap_done       = strap_done;
      if (strap_armed && !strap_done) begin
         next_strap_done       = 1'b1;
         next_double_rate_mode = !cfg_sync[FPC_CFG_RATE_BIT]; // R1 R2
         next_boot_space_map   = !cfg_sync[FPC_CFG_JUMP_BIT]; // R3 R4
         next_start_address    = cfg_sync[FPC_CFG_JUMP_BIT] ? FPC_START_USER
                                                            : FPC_START_BOOT; // R3 R4
         next_lock_bits        = cfg_sync[2:0] & FPC_CFG_LOCK_MASK[2:0];
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         double_rate_mode <= 1'b0;
         boot_space_map   <= 1'b0;
         start_address    <= FPC_START_USER;
         lock_bits        <= 3'b111;
         strap_wait       <= 1'b0;
         strap_armed      <= 1'b0;
         strap_done       <= 1'b0;
      end else if (i_ce) begin
         double_rate_mode <= next_double_rate_mode;
         boot_space_map   <= next_boot_space_map;
         start_address    <= next_start_address;
         lock_bits        <= next_lock_bits;
         strap_wait       <= next_strap_wait;
         strap_armed      <= next_strap_armed;
         strap_done       <= next_strap_done;
      end
   end

   // ----------------------------------------
   // Control and status registers
   // ----------------------------------------
   logic [3:0]    key_field;
   logic [3:0]    next_key_field;
   logic          latch_space_map;
   logic          next_latch_space_map;
   fpc_space_type flash_space_select;
   fpc_space_type next_flash_space_select;
   logic          key_armed;
   logic          next_key_armed;
   logic          seq_err;
   logic          next_seq_err;
   logic          loaded;
   logic          next_loaded;
   logic          boot_map_sw;
   logic          next_boot_map_sw;
   logic          prog_busy;
   logic          prog_done;
   logic          ctl_wr;
   logic          sta_wr;
   logic          aux_wr;
   logic          latch_wr;
   logic          launch_ok;
   logic          launch_refused;
   fpc_launch_type launch;
   fpc_launch_type next_launch;
   logic [8:0]    page;
   logic [8:0]    next_page;

   assign ctl_wr = i_sfr.wr && (i_sfr.addr == FPC_FLASH_CONTROL_ADDR);
   assign sta_wr = i_sfr.wr && (i_sfr.addr == FPC_FLASH_STATUS_ADDR);
   assign aux_wr = i_sfr.wr && (i_sfr.addr == FPC_AUX_CONTROL_ADDR);

   // Latch loads only from user or boot code, never from external fetch
   assign latch_wr = i_xdata.wr && latch_space_map
                     && (i_exec_region != FPC_EXEC_EXT) && !prog_busy; // R10 R13

   // Second key decides; user array needs boot code, boot array is never a target
   function automatic logic launch_allowed(input fpc_space_type sp, input fpc_exec_type ex);
      launch_allowed = (ex == FPC_EXEC_BOOT) || (sp == FPC_SPACE_CLRST); // R8 R9
   endfunction : launch_allowed

   always_comb begin
      launch_ok      = 1'b0;
      launch_refused = 1'b0;
      if (ctl_wr && key_armed) begin
         if (i_sfr.wdata[FPC_KEY_MSB:FPC_KEY_LSB] == FPC_KEY_SECOND && !prog_busy
             && launch_allowed(flash_space_select, i_exec_region)) begin
            launch_ok = 1'b1; // R12 R22
         end else begin
            launch_refused = 1'b1; // R22
         end
      end
   end

   always_comb begin
      next_key_field          = key_field;
      next_latch_space_map    = latch_space_map;
      next_flash_space_select = flash_space_select;
      next_key_armed          = key_armed;
      next_seq_err            = seq_err;
      next_loaded             = loaded;
      next_boot_map_sw        = boot_map_sw;
      next_page               = page;
      next_launch             = '0;
      if (ctl_wr) begin
         next_key_field          = i_sfr.wdata[FPC_KEY_MSB:FPC_KEY_LSB];
         next_latch_space_map    = i_sfr.wdata[FPC_MAP_BIT]; // R13
         next_flash_space_select = fpc_space_type'(i_sfr.wdata[FPC_MODE_MSB:FPC_MODE_LSB]);
         next_key_armed          = (i_sfr.wdata[FPC_KEY_MSB:FPC_KEY_LSB] == FPC_KEY_FIRST)
                                   && !key_armed; // R12
      end
      if (sta_wr && !i_sfr.wdata[FPC_SEQUENCE_ERROR_FLAG_BIT]) begin
         next_seq_err = 1'b0;
      end
      if (launch_ok) begin
         next_seq_err = 1'b0; // R20
         next_loaded  = 1'b0; // R21
         next_launch  = '{start: 1'b1, space: flash_space_select, page: page};
      end else if (launch_refused) begin
         next_seq_err = 1'b1; // R20
      end
      if (latch_wr) begin
         next_loaded = 1'b1; // R21
         next_page   = i_xdata.addr[15:7]; // R19
      end
      if (aux_wr) begin
         next_boot_map_sw = i_sfr.wdata[FPC_BOOTMAP_BIT];
      end else if (strap_armed && !strap_done) begin
         next_boot_map_sw = next_boot_space_map; // R3 R4
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         key_field          <= FPC_CONTROL_RESET[FPC_KEY_MSB:FPC_KEY_LSB]; // R17
         latch_space_map    <= FPC_CONTROL_RESET[FPC_MAP_BIT];
         flash_space_select <= FPC_SPACE_USER;
         key_armed          <= 1'b0;
         seq_err            <= FPC_STATUS_RESET[FPC_SEQUENCE_ERROR_FLAG_BIT];
         loaded             <= FPC_STATUS_RESET[FPC_LOADED_BIT];
         boot_map_sw        <= 1'b0;
         page               <= '0;
         launch             <= '0;
      end else if (i_ce) begin
         key_field          <= next_key_field;
         latch_space_map    <= next_latch_space_map;
         flash_space_select <= next_flash_space_select;
         key_armed          <= next_key_armed;
         seq_err            <= next_seq_err;
         loaded             <= next_loaded;
         boot_map_sw        <= next_boot_map_sw;
         page               <= next_page;
         launch             <= next_launch;
      end
   end

   // ----------------------------------------
   // Sub-blocks
   // ----------------------------------------
   fpc_column_latch #(.DEPTH(FPC_PAGE_BYTES)) fpc_column_latch_i (
      .i_mclk     (i_mclk),
      .i_rst_n    (i_rst_n),
      .i_ce       (i_ce),
      .i_wr       (latch_wr),
      .i_idx      (i_xdata.addr[6:0]), // R19
      .i_wdata    (i_xdata.wdata),
      .i_clear    (launch.start),
      .i_rd_idx   (i_latch_rd_idx),
      .o_rd_data  (o_latch_rd_data),
      .o_rd_valid (o_latch_rd_valid)
   );

   fpc_prog_timer #(.CYCLES(PROG_CYCLES)) fpc_prog_timer_i (
      .i_mclk  (i_mclk),
      .i_rst_n (i_rst_n),
      .i_ce    (i_ce),
      .i_start (launch.start), // R14
      .o_busy  (prog_busy),
      .o_done  (prog_done)
   );

   // ----------------------------------------
   // Read side and outputs
   // ----------------------------------------
   logic [7:0] sfr_rdata;
   logic [7:0] next_sfr_rdata;

   // Latch contents never appear here; of the security byte only the boot map bit shows, in the aux register
   always_comb begin
      next_sfr_rdata = 8'h00; // R7
      if (i_sfr.rd) begin
         case (i_sfr.addr)
            FPC_FLASH_CONTROL_ADDR: next_sfr_rdata = {key_field, latch_space_map,
                                                      flash_space_select, prog_busy}; // R11 R16
            FPC_FLASH_STATUS_ADDR:  next_sfr_rdata = {6'h00, seq_err, loaded}; // R11
            FPC_AUX_CONTROL_ADDR:   next_sfr_rdata = {2'b00, boot_map_sw, 5'h00}; // R11
            default:                next_sfr_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         sfr_rdata <= 8'h00;
      end else if (i_ce) begin
         sfr_rdata <= next_sfr_rdata;
      end
   end

   // Lock bits are taken from the security byte only; no software path writes them
   assign o_general_lock_bits = lock_bits; // R5
   assign o_sfr_rdata         = sfr_rdata;
   assign o_xdata_to_ram      = i_xdata.wr && !latch_space_map; // R13
   assign o_code_space        = flash_space_select; // R18
   assign o_code_read_ok      = (i_exec_region != FPC_EXEC_EXT)
                                || (lock_bits == LOCK_READ_OK); // R10
   assign o_double_rate_mode  = double_rate_mode;
   assign o_clocks_per_cycle  = double_rate_mode ? 4'(FPC_RATE_DOUBLE)
                                                 : 4'(FPC_RATE_SINGLE); // R1 R2
   assign o_start_address     = start_address;
   assign o_boot_space_map    = boot_map_sw;
   assign o_launch            = launch;
   assign o_program_busy_flag = prog_busy; // R14

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_busy_after_launch;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (i_ce && launch.start) |=> prog_busy;
   endproperty
   a_busy_after_launch: assert property (p_busy_after_launch) // R14
      else $error("busy not set after launch");

   property p_busy_ends;
      @(posedge i_mclk) disable iff (!i_rst_n)
      prog_done |-> !prog_busy;
   endproperty
   a_busy_ends: assert property (p_busy_ends) // R15
      else $error("busy still set after done");

   property p_busy_ignores_sw;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (ctl_wr && !prog_busy && !launch.start) |=> !prog_busy;
   endproperty
   a_busy_ignores_sw: assert property (p_busy_ignores_sw) // R16
      else $error("software changed busy");

   property p_no_launch_busy;
      @(posedge i_mclk) disable iff (!i_rst_n)
      prog_busy |=> !launch.start;
   endproperty
   a_no_launch_busy: assert property (p_no_launch_busy) // R22
      else $error("launch while busy");

   property p_user_needs_boot;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (launch_ok && flash_space_select != FPC_SPACE_CLRST) |-> i_exec_region == FPC_EXEC_BOOT;
   endproperty
   a_user_needs_boot: assert property (p_user_needs_boot) // R8
      else $error("launch outside boot code");

   property p_no_ext_load;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (i_exec_region == FPC_EXEC_EXT) |-> !latch_wr;
   endproperty
   a_no_ext_load: assert property (p_no_ext_load) // R10
      else $error("latch load from external code");

   property p_sequence_error_flag_set;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (i_ce && launch_refused) |=> seq_err;
   endproperty
   a_sequence_error_flag_set: assert property (p_sequence_error_flag_set) // R20
      else $error("sequence error not flagged");

   property p_loaded_set;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (i_ce && latch_wr) |=> loaded ##1 (loaded || $past(launch_ok));
   endproperty
   a_loaded_set: assert property (p_loaded_set) // R21
      else $error("loaded flag not set");

   property p_ram_steer;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (i_xdata.wr && latch_space_map) |-> !o_xdata_to_ram;
   endproperty
   a_ram_steer: assert property (p_ram_steer) // R13
      else $error("latch write leaked to ram");

endmodule : fpc_flash_program_control

// file: tb/fpc_core_model.sv
// Core model issuing register moves and external data moves
`timescale 1ns/1ps
module fpc_core_model
   import fpc_pkg::*;
(
   input  wire logic       i_mclk,
   input  wire logic [7:0] i_sfr_rdata,
   output fpc_sfr_type     o_sfr,
   output fpc_xdata_type   o_xdata
);
   initial begin
      o_sfr   = '0;
      o_xdata = '0;
   end
   // -------------------------------------
   // Moves: strobe one cycle, payload inverted on release
   // -------------------------------------
   task automatic sfr_wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge i_mclk);
      o_sfr <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(posedge i_mclk);
      o_sfr <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~v};
   endtask : sfr_wr
   task automatic sfr_rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge i_mclk);
      o_sfr <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge i_mclk);
      o_sfr <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
      #1 v = i_sfr_rdata;
   endtask : sfr_rd
   task automatic xd_wr(input logic [15:0] a, input logic [7:0] v);
      @(posedge i_mclk);
      o_xdata <= '{wr: 1'b1, addr: a, wdata: v};
      @(posedge i_mclk);
      o_xdata <= '{wr: 1'b0, addr: ~a, wdata: ~v};
   endtask : xd_wr
endmodule : fpc_core_model

// file: tb/tb_flash_program_control.sv
// Self-checking bench for the flash program control block
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin miscompares++; \
   $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end
module tb_flash_program_control
   import fpc_pkg::*;
;
   logic           i_mclk   = 1'b0;
   logic           i_rst_n  = 1'b0;
   logic [7:0]     cfg_byte = 8'hff;
   logic [6:0]     rd_idx   = 7'h00;
   fpc_exec_type   exec     = FPC_EXEC_BOOT;
   fpc_sfr_type    sfr;
   fpc_xdata_type  xd;
   fpc_launch_type launch;
   fpc_launch_type got;
   fpc_space_type  space;
   logic [7:0]     rdata, lat_data, d;
   logic [15:0]    start_addr;
   logic [3:0]     cpc;
   logic [2:0]     lock;
   logic           to_ram, read_ok, dbl, boot_map, busy, seen, lat_valid;
   int             miscompares = 0;
   int             check_count = 0;
   always #50 i_mclk = ~i_mclk;

   fpc_core_model fpc_core_model_i (.i_mclk(i_mclk), .i_sfr_rdata(rdata), .o_sfr(sfr),
      .o_xdata(xd));
   fpc_flash_program_control #(.PROG_CYCLES(5)) fpc_flash_program_control_i (
      .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(1'b1), .i_sfr(sfr), .o_sfr_rdata(rdata),
      .i_xdata(xd), .o_xdata_to_ram(to_ram), .i_exec_region(exec), .i_code_addr(16'h0000),
      .o_code_space(space), .o_code_read_ok(read_ok), .i_security_config_byte(cfg_byte),
      .o_double_rate_mode(dbl), .o_clocks_per_cycle(cpc), .o_start_address(start_addr),
      .o_boot_space_map(boot_map), .o_general_lock_bits(lock), .o_launch(launch),
      .o_program_busy_flag(busy), .o_latch_rd_data(lat_data), .o_latch_rd_valid(lat_valid),
      .i_latch_rd_idx(rd_idx));

   // -------------------------------------
   // Shared tasks
   // -------------------------------------
   task automatic end_of_test;
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_of_test
   // Straps settle a few edges after release, so wait past that
   task automatic do_reset(input logic [7:0] c);
      @(posedge i_mclk);
      cfg_byte <= c;
      i_rst_n  <= 1'b0;
      repeat (20) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      repeat (6) @(posedge i_mclk);
      #1;
   endtask : do_reset
   task automatic wait_launch;
      seen = 1'b0;
      for (int i = 0; i < 5 && !seen; i++) begin
         #1;
         if (launch.start === 1'b1) begin
            seen = 1'b1;
            got  = launch;
         end else begin
            @(posedge i_mclk);
         end
      end
   endtask : wait_launch
   // Bounded poll, as software must before reusing the latches
   task automatic wait_idle;
      int n;
      n = 0;
      while (busy !== 1'b0) begin
         @(posedge i_mclk);
         #1 n++;
         if (n > 30) begin
            miscompares++;
            end_of_test();
         end
      end
   endtask : wait_idle

   // -------------------------------------
   // Scenarios
   // -------------------------------------
   task automatic t_reset;
      do_reset(8'h3d);
      `CHK({dbl, cpc, start_addr, boot_map, lock}, {1'b1, 4'h6, 16'hf800, 1'b1, 3'b101})
      `CHK(start_addr, 16'hf800)
      do_reset(8'hff);
      `CHK({dbl, cpc, boot_map, lock}, {1'b0, 4'hc, 1'b0, 3'b111})
      `CHK(start_addr, 16'h0000)
      fpc_core_model_i.sfr_rd(FPC_FLASH_CONTROL_ADDR, d);
      `CHK(d, 8'h00)
      fpc_core_model_i.sfr_wr(FPC_AUX_CONTROL_ADDR, 8'h20);
      #1 `CHK(boot_map, 1'b1)
      $display("test reset done");
   endtask : t_reset
   task automatic t_program;
      exec <= FPC_EXEC_BOOT;
      for (int m = 0; m < 4; m++) begin
         fpc_core_model_i.sfr_wr(FPC_FLASH_CONTROL_ADDR, 8'(m << 1));
         #1 `CHK(space, 2'(m))
      end
      fork
         fpc_core_model_i.xd_wr(16'h0010, 8'h11);
         begin
            @(posedge i_mclk);
            #1 `CHK(to_ram, 1'b1)
         end
      join
      fpc_core_model_i.sfr_wr(FPC_FLASH_CONTROL_ADDR, 8'h08);
      fork
         fpc_core_model_i.xd_wr(16'h0185, 8'h3c);
         begin
            @(posedge i_mclk);
            #1 `CHK(to_ram, 1'b0)
         end
      join
      rd_idx <= 7'h05;
      fpc_core_model_i.sfr_rd(FPC_FLASH_STATUS_ADDR, d);
      `CHK(d[0], 1'b1)
      `CHK({lat_valid, lat_data}, {1'b1, 8'h3c})
      fpc_core_model_i.sfr_wr(FPC_FLASH_CONTROL_ADDR, 8'h58);
      fpc_core_model_i.sfr_wr(FPC_FLASH_CONTROL_ADDR, 8'ha8);
      wait_launch();
      `CHK({seen, got.space, got.page}, {1'b1, 2'b00, 9'h003})
      fpc_core_model_i.sfr_wr(FPC_FLASH_CONTROL_ADDR, 8'h08);
      #1 `CHK(busy, 1'b1)
      fpc_core_model_i.sfr_rd(FPC_FLASH_CONTROL_ADDR, d);
      `CHK(d[0], 1'b1)
      wait_idle();
      fpc_core_model_i.sfr_rd(FPC_FLASH_STATUS_ADDR, d);
      `CHK(d[0], 1'b0)
      `CHK(lat_valid, 1'b0)
      $display("test program done");
   endtask : t_program
   task automatic t_refuse;
      exec <= FPC_EXEC_USER;
      fpc_core_model_i.sfr_wr(FPC_FLASH_CONTROL_ADDR, 8'h50);
      fpc_core_model_i.sfr_wr(FPC_FLASH_CONTROL_ADDR, 8'ha0);
      wait_launch();
      `CHK(seen, 1'b0)
      exec <= FPC_EXEC_BOOT;
      fpc_core_model_i.sfr_wr(FPC_FLASH_CONTROL_ADDR, 8'h50);
      fpc_core_model_i.sfr_wr(FPC_FLASH_CONTROL_ADDR, 8'h30);
      wait_launch();
      `CHK(seen, 1'b0)
      fpc_core_model_i.sfr_rd(FPC_FLASH_STATUS_ADDR, d);
      `CHK(d[1], 1'b1)
      fpc_core_model_i.sfr_wr(FPC_FLASH_CONTROL_ADDR, 8'h56);
      fpc_core_model_i.sfr_wr(FPC_FLASH_CONTROL_ADDR, 8'ha6);
      wait_launch();
      `CHK({seen, got.space}, {1'b1, 2'b11})
      wait_idle();
      fpc_core_model_i.sfr_rd(FPC_FLASH_STATUS_ADDR, d);
      `CHK(d[1], 1'b0)
      $display("test refuse done");
   endtask : t_refuse
   task automatic t_external;
      exec <= FPC_EXEC_EXT;
      fpc_core_model_i.sfr_wr(FPC_FLASH_CONTROL_ADDR, 8'h08);
      fpc_core_model_i.xd_wr(16'h0200, 8'h5a);
      fpc_core_model_i.sfr_rd(FPC_FLASH_STATUS_ADDR, d);
      `CHK({d[0], read_ok}, 2'b01)
      do_reset(8'hfd);
      `CHK(read_ok, 1'b0)
      $display("test external done");
   endtask : t_external

   initial begin
      do_reset(8'hff);
      t_reset();
      t_program();
      t_refuse();
      t_external();
      end_of_test();
   end
endmodule : tb_flash_program_control
